// file: pkg/pin_map.svh
/*
 * Register offsets, field values, reset values and retry counts for the
 * PIN state and file life-cycle command block.
 * Assumes an 8-bit APB byte address and 32-bit data words.
 */
`ifndef PIN_MAP_SVH
`define PIN_MAP_SVH

// register byte offsets
`define REG_CMD         8'h00
`define REG_SW          8'h04
`define REG_PIN         8'h08
`define REG_CTRL        8'h0C
`define REG_ACCESS      8'h10
`define REG_FILE        8'h14
`define REG_DATA0       8'h20
`define REG_DATA3       8'h2C
`define REG_FID_BASE    8'h40

// reset values
`define CMD_RESET       32'h0000_0000
`define SW_RESET        16'h0000
`define ACCESS_RESET    32'h0000_0000

// retry counter starting values
`define PIN_TRIES_INIT  3
`define UB_TRIES_INIT   10

// command field values
`define LC_EMPTY        8'h00
`define LC_ENABLE       8'h08
`define LC_UNBLOCK      8'h10
`define LC_PATH_MAX     8'h10
`define P1_ZERO         8'h00
`define P1_PATH_MF      8'h08
`define P1_PATH_DF      8'h09
`define P2_ZERO         8'h00

// usage qualifier for the alternative global key
`define QUAL_DO_NOT_USE 8'h00

// status words
`define SW_RETRY_TAG    12'h63C
`define SW_UB_BLOCKED   16'h6983

`endif

// file: pkg/pin_pkg.sv
/*
 * Types shared by the PIN state and file life-cycle block.
 * Assumes the command word is written as one 32-bit APB word.
 */
package pin_pkg;

    // command selector in the low bits of the command word
    typedef enum logic [1:0] {
        OP_ENABLE     = 2'b00,
        OP_UNBLOCK    = 2'b01,
        OP_DEACTIVATE = 2'b10,
        OP_ACTIVATE   = 2'b11
    } cmd_op_t;

    // command word layout, low bit first at the bottom
    typedef struct packed {
        logic [7:0] lc;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [5:0] rsv;
        cmd_op_t    op;
    } cmd_t;

    // enable and block flags of a PIN
    typedef struct packed {
        logic enabled;
        logic blocked;
    } pin_flags_t;

endpackage : pin_pkg

// file: src/retry_counter.sv
/*
 * Saturating retry counter with reload to its starting value.
 * Assumes reload and decrement are never asked in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module retry_counter #(
    parameter int             W    = 4,
    parameter logic [W-1:0]   INIT = '1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         reload,
    input  wire logic         dec,
    // state
    output logic [W-1:0]      count,
    output logic              last
);

    // nonvolatile in a real card; here it restarts at reset or on reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= INIT;
        end else if (reload) begin
            count <= INIT;
        end else if (dec && count != '0) begin
            count <= count - 1'b1;
        end
    end

    // one try left: the next failure exhausts it
    assign last = (count == W'(1));

endmodule : retry_counter

`default_nettype wire

// file: src/file_lookup.sv
/*
 * Matches a file id against the table of elementary file ids.
 * Assumes ids are packed sixteen bits per file, file 0 lowest.
 */
`timescale 1ns/100ps
`default_nettype none

module file_lookup #(
    parameter int N     = 8,
    parameter int IDX_W = 3
) (
    // table and key
    input  wire logic [N*16-1:0] ids,
    input  wire logic [15:0]     key,
    // result
    output logic                 hit,
    output logic [IDX_W-1:0]     idx
);

    // lowest index wins when two entries carry the same id
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (ids[i*16 +: 16] == key) begin
                hit = 1'b1;
                idx = IDX_W'(i);
            end
        end
    end

endmodule : file_lookup

`default_nettype wire

// file: src/pin_state_and_file_lifecycle.sv
/*
 * Card-side interpreter for the enable, unblock, deactivate and activate
 * commands, with its command, data and state registers on an APB slave.
 * Assumes command framing and transport are done outside; software loads
 * the data words, then writes the command word, which executes at once.
 */
// Summary of operation
// - enable carries P1 zero, length eight, eight-byte PIN, no response length.
// - enable is refused when the PIN is already enabled or blocked.
// - correct PIN on enable reloads counter to three and enables the PIN.
// - wrong PIN on enable decrements the counter, PIN stays disabled; with BLOCK_SETS_ENABLED set, the blocking try enables it.
// - three wrong tries block the PIN; only unblock clears it.
// - blocked and disabled grants access; blocked and enabled never does.
// - enabling a replaced PIN sets the alternative key qualifier to do-not-use.
// - every successful enable asks for security environment revalidation.
// - correct unblock code stores new PIN, reloads both counters, enables PIN.
// - wrong unblock code decrements its counter and answers 63C9 to 63C1.
// - the tenth wrong unblock code blocks it and answers 63C0.
// - unblock with data on a blocked unblock code answers 6983.
// - wrong unblock code leaves all PIN state untouched.
// - empty unblock is a counter query answering 63CX, always allowed.
// - query of a blocked unblock code answers 6983.
// - unblock carries P1 zero and length empty or sixteen.
// - deactivation runs only with its access condition and sets the flag.
// - success makes the target the current file; failure changes nothing.
// - a deactivated file refuses all but selection and reactivation.
// - file commands need P2 zero and P1 of 00, 08 or 09.
// - P1 and P2 zero with empty data target the current file.
// - activation runs only with its access condition and clears the flag.
// - activation uses the same addressing as deactivation.
`timescale 1ns/100ps
`default_nettype none

`include "pin_map.svh"

module pin_state_and_file_lifecycle #(
    parameter int          NUM_FILES          = 8,
    parameter int          IDX_W              = 3,
    parameter int          PIN_CNT_W          = 2,
    parameter int          UB_CNT_W           = 4,
    parameter logic        BLOCK_SETS_ENABLED = 1'b0,
    parameter logic [63:0] PIN_INIT           = 64'h0000_0000_0000_0000,
    parameter logic [63:0] UB_INIT            = 64'h0000_0000_0000_0000,
    parameter logic [15:0] SW_OK              = 16'h9000,
    parameter logic [15:0] SW_REFUSED         = 16'h6985,
    parameter logic [15:0] SW_NO_ACCESS       = 16'h6982,
    parameter logic [15:0] SW_BAD_PARAM       = 16'h6B00,
    parameter logic [15:0] SW_NOT_FOUND       = 16'h6A82
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // state towards the rest of the card
    output logic             se_revalidate,
    output logic             pin_gate_open,
    output logic             cur_ef_locked
);

    // register state
    pin_pkg::cmd_t           cmd_r;
    logic [15:0]             sw_r;
    pin_pkg::pin_flags_t     pin_r;
    logic                    ub_blocked_r;
    logic [63:0]             pin_ref_r;
    logic [63:0]             ub_ref_r;
    logic                    verified_r;
    logic [7:0]              qual_r;
    logic [31:0]             access_r;
    logic [31:0]             data_r [4];
    logic [NUM_FILES*16-1:0] fid_r;
    logic [NUM_FILES-1:0]    deact_r;
    logic                    cur_valid_r;
    logic [IDX_W-1:0]        cur_idx_r;
    logic [31:0]             prdata_r;
    logic                    reval_r;

    // next values from the command decode
    logic [15:0]             sw_nxt;
    pin_pkg::pin_flags_t     pin_nxt;
    logic                    ub_blocked_nxt;
    logic [63:0]             pin_ref_nxt;
    logic [7:0]              qual_nxt;
    logic [NUM_FILES-1:0]    deact_nxt;
    logic                    cur_valid_nxt;
    logic [IDX_W-1:0]        cur_idx_nxt;
    logic                    reval_nxt;
    logic                    pin_reload;
    logic                    pin_dec;
    logic                    ub_reload;
    logic                    ub_dec;

    // decode helpers
    logic                    wr_take;
    logic                    addr_hit;
    logic                    cmd_go;
    pin_pkg::cmd_t           cmd_in;
    logic [31:0]             rd_word;
    logic [127:0]            data_flat;
    logic [3:0]              id_pos;
    logic [15:0]             key_id;
    logic                    key_hit;
    logic [IDX_W-1:0]        key_idx;
    logic [PIN_CNT_W-1:0]    pin_cnt;
    logic                    pin_last;
    logic [UB_CNT_W-1:0]     ub_cnt;
    logic                    ub_last;
    logic                    fid_sel;
    logic [3:0]              fid_idx;

    // apb handshake: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign wr_take   = psel & penable & pwrite;
    assign fid_sel   = (paddr[7:6] == 2'b01);
    assign fid_idx   = paddr[5:2];
    assign pslverr   = psel & penable & ~addr_hit;
    assign cmd_in    = pin_pkg::cmd_t'(pwdata);
    assign cmd_go    = wr_take & (paddr == `REG_CMD);
    assign data_flat = {data_r[3], data_r[2], data_r[1], data_r[0]};

    // read mux and address map
    always_comb begin
        addr_hit = 1'b1;
        rd_word  = 32'h0000_0000;
        if (fid_sel && paddr[1:0] == 2'b00 && int'(fid_idx) < NUM_FILES) begin
            rd_word = {16'h0000, fid_r[fid_idx*16 +: 16]};
        end else begin
            unique case (paddr)
                `REG_CMD:    rd_word = {cmd_r.lc, cmd_r.p2, cmd_r.p1, 6'h00, cmd_r.op};
                `REG_SW:     rd_word = {16'h0000, sw_r};
                `REG_PIN:    rd_word = {16'h0000, 4'(ub_cnt), 3'h0, ub_blocked_r,
                                        4'(pin_cnt), 2'h0, pin_r.blocked, pin_r.enabled};
                `REG_CTRL:   rd_word = {16'h0000, qual_r, 7'h00, verified_r};
                `REG_ACCESS: rd_word = access_r;
                `REG_FILE:   rd_word = {16'h0000, 1'b0, 3'(cur_idx_r), 3'h0, cur_valid_r,
                                        8'(deact_r)};
                8'h20:       rd_word = data_r[0];
                8'h24:       rd_word = data_r[1];
                8'h28:       rd_word = data_r[2];
                8'h2C:       rd_word = data_r[3];
                default:     addr_hit = 1'b0;
            endcase
        end
    end

    // read data is caught in the setup cycle so prdata leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_word;
        end
    end
    assign prdata = prdata_r;

    // retry counters, shared form for PIN and unblock code
    retry_counter #(
        .W    (PIN_CNT_W),
        .INIT (PIN_CNT_W'(`PIN_TRIES_INIT))
    ) u_pin_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .reload  (pin_reload),
        .dec     (pin_dec),
        .count   (pin_cnt),
        .last    (pin_last)
    );

    retry_counter #(
        .W    (UB_CNT_W),
        .INIT (UB_CNT_W'(`UB_TRIES_INIT))
    ) u_ub_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .reload  (ub_reload),
        .dec     (ub_dec),
        .count   (ub_cnt),
        .last    (ub_last)
    );

    // file id is the last two data bytes, first byte high
    assign id_pos = 4'(cmd_in.lc - 8'h02);
    assign key_id = {data_flat[{id_pos, 3'b000} +: 8], data_flat[{4'(id_pos + 4'h1), 3'b000} +: 8]};

    file_lookup #(
        .N     (NUM_FILES),
        .IDX_W (IDX_W)
    ) u_lookup (
        .ids (fid_r),
        .key (key_id),
        .hit (key_hit),
        .idx (key_idx)
    );

    // command execution; defaults keep every piece of state as it is, except the revalidation pulse, which drops
    always_comb begin
        logic [IDX_W-1:0] tgt;
        logic             tgt_ok;
        tgt            = cur_idx_r;
        tgt_ok         = 1'b0;
        sw_nxt         = sw_r;
        pin_nxt        = pin_r;
        ub_blocked_nxt = ub_blocked_r;
        pin_ref_nxt    = pin_ref_r;
        qual_nxt       = qual_r;
        deact_nxt      = deact_r;
        cur_valid_nxt  = cur_valid_r;
        cur_idx_nxt    = cur_idx_r;
        reval_nxt      = 1'b0;
        pin_reload     = 1'b0;
        pin_dec        = 1'b0;
        ub_reload      = 1'b0;
        ub_dec         = 1'b0;
        if (cmd_go) begin
            unique case (cmd_in.op)
                pin_pkg::OP_ENABLE: begin
                    if (cmd_in.p1 != `P1_ZERO || cmd_in.lc != `LC_ENABLE) begin
                        sw_nxt = SW_BAD_PARAM;
                    end else if (pin_r.enabled || pin_r.blocked) begin
                        sw_nxt = SW_REFUSED;
                    end else if (data_flat[63:0] == pin_ref_r) begin
                        pin_reload      = 1'b1;
                        pin_nxt.enabled = 1'b1;
                        qual_nxt        = `QUAL_DO_NOT_USE;
                        reval_nxt       = 1'b1;
                        sw_nxt          = SW_OK;
                    end else begin
                        pin_dec = 1'b1;
                        sw_nxt  = {`SW_RETRY_TAG, 4'(pin_cnt - 1'b1)};
                        if (pin_last) begin
                            pin_nxt.blocked = 1'b1;
                            pin_nxt.enabled = BLOCK_SETS_ENABLED;
                        end
                    end
                end
                pin_pkg::OP_UNBLOCK: begin
                    if (cmd_in.p1 != `P1_ZERO ||
                        (cmd_in.lc != `LC_EMPTY && cmd_in.lc != `LC_UNBLOCK)) begin
                        sw_nxt = SW_BAD_PARAM;
                    end else if (cmd_in.lc == `LC_EMPTY) begin
                        sw_nxt = ub_blocked_r ? `SW_UB_BLOCKED : {`SW_RETRY_TAG, 4'(ub_cnt)};
                    end else if (ub_blocked_r) begin
                        sw_nxt = `SW_UB_BLOCKED;
                    end else if (data_flat[63:0] == ub_ref_r) begin
                        pin_ref_nxt = data_flat[127:64];
                        ub_reload   = 1'b1;
                        pin_reload  = 1'b1;
                        pin_nxt     = '{enabled: 1'b1, blocked: 1'b0};
                        sw_nxt      = SW_OK;
                    end else begin
                        ub_dec = 1'b1;
                        sw_nxt = {`SW_RETRY_TAG, 4'(ub_cnt - 1'b1)};
                        if (ub_last) begin
                            ub_blocked_nxt = 1'b1;
                        end
                    end
                end
                default: begin
                    if (cmd_in.p2 != `P2_ZERO ||
                        (cmd_in.p1 != `P1_ZERO && cmd_in.p1 != `P1_PATH_MF &&
                         cmd_in.p1 != `P1_PATH_DF)) begin
                        sw_nxt = SW_BAD_PARAM;
                    end else if (cmd_in.p1 == `P1_ZERO && cmd_in.lc == `LC_EMPTY) begin
                        tgt_ok = cur_valid_r;
                        sw_nxt = cur_valid_r ? SW_OK : SW_NOT_FOUND;
                    end else if (cmd_in.lc < 8'h02 || cmd_in.lc > `LC_PATH_MAX || cmd_in.lc[0] ||
                                 (cmd_in.p1 == `P1_ZERO && cmd_in.lc != 8'h02)) begin
                        sw_nxt = SW_BAD_PARAM;
                    end else begin
                        tgt    = key_idx;
                        tgt_ok = key_hit;
                        sw_nxt = key_hit ? SW_OK : SW_NOT_FOUND;
                    end
                    if (tgt_ok && cmd_in.op == pin_pkg::OP_DEACTIVATE) begin
                        if (!access_r[tgt]) begin
                            tgt_ok = 1'b0;
                            sw_nxt = SW_NO_ACCESS;
                        end else if (deact_r[tgt]) begin
                            tgt_ok = 1'b0;
                            sw_nxt = SW_REFUSED;
                        end else begin
                            deact_nxt[tgt] = 1'b1;
                        end
                    end else if (tgt_ok) begin
                        if (!access_r[16 + int'(tgt)]) begin
                            tgt_ok = 1'b0;
                            sw_nxt = SW_NO_ACCESS;
                        end else begin
                            deact_nxt[tgt] = 1'b0;
                        end
                    end
                    if (tgt_ok) begin
                        cur_valid_nxt = 1'b1;
                        cur_idx_nxt   = tgt;
                    end
                end
            endcase
        end
    end

    // unblock code reference; no command in this block replaces it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ub_ref_r <= 64'h0000_0000_0000_0000;
        end else if (ub_ref_r != UB_INIT && !cmd_go) begin
            ub_ref_r <= UB_INIT; // loaded after release, never from a port
        end
    end

    // command word and status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= pin_pkg::cmd_t'(`CMD_RESET);
            sw_r  <= `SW_RESET;
        end else begin
            if (cmd_go) begin
                cmd_r <= cmd_in;
            end
            sw_r <= sw_nxt;
        end
    end

    // PIN flags, reference and key qualifier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r        <= '{enabled: 1'b0, blocked: 1'b0}; // disabled: nothing else here can disable it
            ub_blocked_r <= 1'b0;
            pin_ref_r    <= PIN_INIT;
            qual_r       <= `QUAL_DO_NOT_USE;
            reval_r      <= 1'b0;
        end else begin
            pin_r        <= pin_nxt;
            ub_blocked_r <= ub_blocked_nxt;
            pin_ref_r    <= pin_ref_nxt;
            reval_r      <= reval_nxt;
            // software marks a replacement key; a successful enable retires it
            if (wr_take && paddr == `REG_CTRL && !cmd_go) begin
                qual_r <= pwdata[15:8];
            end else begin
                qual_r <= qual_nxt;
            end
        end
    end

    // software written control: verification outcome and access conditions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verified_r <= 1'b0;
            access_r   <= `ACCESS_RESET;
        end else if (wr_take) begin
            if (paddr == `REG_CTRL) begin
                verified_r <= pwdata[0];
            end
            if (paddr == `REG_ACCESS) begin
                access_r <= pwdata;
            end
        end
    end

    // data words and file id table
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= '{default: 32'h0000_0000};
            fid_r  <= '0;
        end else if (wr_take) begin
            if (paddr >= `REG_DATA0 && paddr <= `REG_DATA3 && paddr[1:0] == 2'b00) begin
                data_r[paddr[3:2]] <= pwdata;
            end
            if (fid_sel && paddr[1:0] == 2'b00 && int'(fid_idx) < NUM_FILES) begin
                fid_r[fid_idx*16 +: 16] <= pwdata[15:0];
            end
        end
    end

    // life-cycle flags and current file pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deact_r     <= '0;
            cur_valid_r <= 1'b0;
            cur_idx_r   <= '0;
        end else begin
            deact_r     <= deact_nxt;
            cur_valid_r <= cur_valid_nxt;
            cur_idx_r   <= cur_idx_nxt;
        end
    end

    assign pin_gate_open = ~pin_r.enabled | (verified_r & ~pin_r.blocked);
    assign cur_ef_locked = cur_valid_r & deact_r[cur_idx_r];
    assign se_revalidate = reval_r;

endmodule : pin_state_and_file_lifecycle

`default_nettype wire

// file: verification/apb_terminal.sv
/* terminal model: apb master carrying command words.
   assumes the slave may stall; waits are bounded */
`timescale 1ns/100ps
`default_nettype none
module apb_terminal (
    // clock and answer
    input  wire logic        pclk, pready,
    input  wire logic [31:0] prdata,
    // request
    output logic             psel, penable, pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    logic hung = 1'b0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // one transfer, held until pready is sampled high or 16 wait cycles pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
        hung = (n >= 16);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data shows the inverse, never a stale match
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_terminal
`default_nettype wire

// file: verification/pin_chk.sv
/* port checker for the pin block; bound to its top ports */
`timescale 1ns/100ps
`default_nettype none
module pin_chk (
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic        se_revalidate, pin_gate_open, cur_ef_locked,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire cmd_w = acc && pwrite && paddr == 8'h00;
    // bus answers at once, error only off the map
    a_ready_now: assert property (acc |-> pready) else $error("pready low");
    a_err_off: assert property (acc && paddr == 8'h18 |-> pslverr) else $error("no error");
    a_err_on: assert property (acc && paddr == 8'h04 |-> !pslverr) else $error("false error");
    a_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
    // state outputs move only after a write
    a_reval_once: assert property (se_revalidate |=> !se_revalidate) else $error("long pulse");
    a_reval_cmd: assert property (se_revalidate |-> $past(cmd_w)) else $error("stray pulse");
    a_gate_write: assert property (!$stable(pin_gate_open) |-> $past(acc && pwrite)) else $error("gate");
    a_lock_cmd: assert property (!$stable(cur_ef_locked) |-> $past(cmd_w)) else $error("lock");
endmodule : pin_chk
bind pin_state_and_file_lifecycle pin_chk pin_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .pslverr, .se_revalidate, .pin_gate_open, .cur_ef_locked, .paddr, .prdata);
`default_nettype wire

// file: verification/pin_state_and_file_lifecycle_test.sv
/* bench for the pin block; terminal model drives apb */
`timescale 1ns/100ps
`default_nettype none
`include "pin_map.svh"
module pin_state_and_file_lifecycle_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic        se_revalidate, pin_gate_open, cur_ef_locked, rv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    int          miscompares = 0, comparisons = 0;
    initial forever #20 pclk = ~pclk;
    pin_state_and_file_lifecycle #(.UB_INIT(64'hA5A5_A5A5_A5A5_A5A5)) pin_state_and_file_lifecycle_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .se_revalidate, .pin_gate_open, .cur_ef_locked);
    apb_terminal apb_terminal_i (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // a hung bus ends the run at once
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb_terminal_i.xfer(w, a, d, r);
        if (apb_terminal_i.hung) begin
            miscompares++;
            end_sim();
        end
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rd
    task automatic cmd(input pin_pkg::cmd_op_t op, input logic [7:0] p1, lc, input logic [15:0] sw);
        bus(1'b1, `REG_CMD, {lc, `P2_ZERO, p1, 6'h00, op});
        @(negedge pclk) rv = se_revalidate; // pulse stands one cycle only
        rd(`REG_SW, {16'h0000, sw});
    endtask : cmd
    task automatic ub(input logic [7:0] lc, input logic [15:0] sw);
        cmd(pin_pkg::OP_UNBLOCK, `P1_ZERO, lc, sw);
    endtask : ub
    task automatic en(input logic [15:0] sw);
        cmd(pin_pkg::OP_ENABLE, `P1_ZERO, `LC_ENABLE, sw);
    endtask : en
    // disabled pin: wrong try, right one, refusals; then a reset and three wrong tries block it
    task automatic t_enable;
        chk({31'h0, pin_gate_open}, 32'h1);
        bus(1'b1, `REG_CTRL, 32'h0000_0800);
        bus(1'b1, `REG_DATA0, 32'h0000_0001);
        en(16'h63C2);
        rd(`REG_PIN, 32'h0000_A020);
        bus(1'b1, `REG_DATA0, 32'h0000_0000);
        en(16'h9000);
        chk({31'h0, rv}, 32'h1);
        rd(`REG_PIN, 32'h0000_A031);
        rd(`REG_CTRL, 32'h0000_0000);
        chk({31'h0, pin_gate_open}, 32'h0);
        en(16'h6985);
        chk({31'h0, rv}, 32'h0);
        cmd(pin_pkg::OP_ENABLE, 8'h01, `LC_ENABLE, 16'h6B00);
        rd(`REG_PIN, 32'h0000_A031);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b1, `REG_DATA0, 32'h0000_0001);
        for (int i = 2; i >= 0; i--)
            en({`SW_RETRY_TAG, i[3:0]});
        rd(`REG_PIN, 32'h0000_A002);
        chk({31'h0, pin_gate_open}, 32'h1);
        en(16'h6985);
    endtask : t_enable
    // retries fall to zero and block; pin state untouched
    task automatic t_unblock;
        ub(`LC_EMPTY, 16'h63CA);
        ub(8'h08, 16'h6B00);
        bus(1'b1, `REG_DATA0, 32'h0000_0000);
        ub(`LC_UNBLOCK, 16'h63C9);
        rd(`REG_PIN, 32'h0000_9002);
        bus(1'b1, `REG_DATA0, 32'hA5A5_A5A5);
        bus(1'b1, `REG_DATA0 + 8'h04, 32'hA5A5_A5A5);
        ub(`LC_UNBLOCK, 16'h9000);
        rd(`REG_PIN, 32'h0000_A031);
        bus(1'b1, `REG_DATA0, 32'h0000_0000);
        for (int i = 9; i >= 0; i--)
            ub(`LC_UNBLOCK, {`SW_RETRY_TAG, i[3:0]});
        ub(`LC_UNBLOCK, `SW_UB_BLOCKED);
        ub(`LC_EMPTY, `SW_UB_BLOCKED);
        rd(`REG_PIN, 32'h0000_0131);
    endtask : t_unblock
    // refusals leave files alone; success moves the current file
    task automatic t_files;
        bus(1'b1, `REG_FID_BASE, 32'h0000_2F01);
        bus(1'b1, `REG_DATA0, 32'h0000_012F);
        cmd(pin_pkg::OP_DEACTIVATE, `P1_ZERO, 8'h02, 16'h6982);
        cmd(pin_pkg::OP_DEACTIVATE, 8'h01, 8'h02, 16'h6B00);
        rd(`REG_FILE, 32'h0000_0000);
        bus(1'b1, `REG_ACCESS, 32'h0001_0001);
        cmd(pin_pkg::OP_DEACTIVATE, `P1_PATH_DF, 8'h02, 16'h9000);
        rd(`REG_FILE, 32'h0000_0101);
        chk({31'h0, cur_ef_locked}, 32'h1);
        cmd(pin_pkg::OP_ACTIVATE, `P1_ZERO, `LC_EMPTY, 16'h9000);
        rd(`REG_FILE, 32'h0000_0100);
        rd(8'h18, 32'h0000_0000);
    endtask : t_files
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_enable();
        t_unblock();
        t_files();
        end_sim();
    end
endmodule : pin_state_and_file_lifecycle_test
`default_nettype wire
